/* swid_pkg.sv */
/*
 Shared constants for the single-wire identity read link: commands,
 slot and pulse timing, code layout and counter widths and limits.
 Assumes a 50 MHz system clock and one open-drain line with a pull-up.
*/
// What this block does
// - Master opens with reset, then presence check
// - Command only after presence; always eight bits
// - Slave sends 64-bit code on read command
// - Identity read only with one slave
// - Code: family, 48-bit serial, checksum
// - Search command code only sets the slave search flag
// - No presence: master stops with error
// - Byte sent as eight write slots
// - Byte received from eight read slots
// - First byte stored at highest buffer offset
// - Reset low 480 us, then watch 480 us
// - Slot at least 60 us, 1 us recovery
// - All bits travel least significant first
package swid_pkg;
   localparam int          CLK_HZ        = 50_000_000;
   localparam int          RST_LOW_US    = 480;
   localparam int          PRES_WIN_US   = 480;
   localparam int          SLOT_US       = 60;
   localparam int          REC_US        = 1;
   localparam int          WR0_LOW_US    = 60;
   localparam int          WR1_LOW_US    = 5;
   localparam int          RD_LOW_US     = 2;
   localparam int          RD_SAMPLE_US  = 13;
   localparam int          S_RST_MIN_US  = 300;
   localparam int          S_SAMPLE_US   = 30;
   localparam int          S_PRES_WAIT_US = 30;
   localparam int          S_PRES_US     = 120;
   localparam int          S_DRIVE0_US   = 45;
   localparam int          CYC_PER_US    = CLK_HZ / 1_000_000;
   localparam int          RST_LOW_CYC   = RST_LOW_US * CYC_PER_US;
   localparam int          PRES_WIN_CYC  = PRES_WIN_US * CYC_PER_US;
   localparam int          SLOT_CYC      = SLOT_US * CYC_PER_US;
   localparam int          REC_CYC       = REC_US * CYC_PER_US;
   localparam int          WR0_LOW_CYC   = WR0_LOW_US * CYC_PER_US;
   localparam int          WR1_LOW_CYC   = WR1_LOW_US * CYC_PER_US;
   localparam int          RD_LOW_CYC    = RD_LOW_US * CYC_PER_US;
   localparam int          RD_SAMPLE_CYC = RD_SAMPLE_US * CYC_PER_US;
   localparam int          S_RST_MIN_CYC = S_RST_MIN_US * CYC_PER_US;
   localparam int          S_SAMPLE_CYC  = S_SAMPLE_US * CYC_PER_US;
   localparam int          S_PRES_WAIT_CYC = S_PRES_WAIT_US * CYC_PER_US;
   localparam int          S_PRES_CYC    = S_PRES_US * CYC_PER_US;
   localparam int          S_DRIVE0_CYC  = S_DRIVE0_US * CYC_PER_US;
   localparam int          CNT_W         = 16;
   localparam logic [7:0]  CMD_READ_ID   = 8'h33;
   localparam logic [7:0]  CMD_SEARCH    = 8'hF0;
   localparam int          CODE_BITS     = 64;
   localparam int          CODE_BYTES    = 8;
   localparam int          BIT_W         = 7;
   localparam logic [2:0]  LAST_BIT_IN_BYTE = 3'h7;
   localparam logic [2:0]  LAST_BYTE     = 3'h7;
   localparam logic [6:0]  LAST_CODE_BIT = 7'h3F;
endpackage : swid_pkg

/* swid_if.sv */
/*
 Interface carrying the shared open-drain line between both ends.
 Assumes an external pull-up: the line is high unless someone pulls low.
*/
`timescale 1ns/1ps
interface swid_if;
   logic m_oe;
   logic s_oe;
   logic line;
   // Wired-AND with pull-up
   assign line = ~(m_oe | s_oe);
   modport master (output m_oe, input line);
   modport slave  (output s_oe, input line);
endinterface : swid_if

/* swid_master.sv */
/*
 Bus master end: reset and presence, read-identity command, 64 read
 slots, eight-byte code buffer.
 Assumes the line input is synchronous to sys_clk and one slave present.
*/
`timescale 1ns/1ps
module swid_master
   import swid_pkg::*;
(
   input  wire logic                 sys_clk,
   input  wire logic                 srst,
   input  wire logic                 clk_en,
   swid_if.master                    bus,
   input  wire logic                 start,
   output logic                      busy,
   output logic                      done_r,
   output logic                      err_r,
   output logic [CODE_BITS-1:0]      serial_code_buffer
);
   typedef enum logic [6:0] {
      M_IDLE  = 7'h01,
      M_RLOW  = 7'h02,
      M_PRES  = 7'h04,
      M_WLOW  = 7'h08,
      M_WREC  = 7'h10,
      M_RLOWR = 7'h20,
      M_RWAIT = 7'h40
   } swid_mst_t;

   swid_mst_t                 st_r;
   swid_mst_t                 st_nxt;
   logic [CNT_W-1:0]          cnt_r;
   logic [CNT_W-1:0]          cnt_nxt;
   logic [2:0]                bit_r;
   logic [2:0]                byte_r;
   logic [7:0]                sh_r;
   logic                      pres_r;
   logic [7:0]                rx_r;
   logic [7:0]                buf_r [CODE_BYTES];

   // Counter load for a phase of cyc cycles
   function automatic logic [CNT_W-1:0] span(input int cyc);
      return CNT_W'(cyc - 1);
   endfunction : span

   // Counter load for the released rest of a slot
   function automatic logic [CNT_W-1:0] slot_rest(input int low_cyc);
      return CNT_W'(SLOT_CYC + REC_CYC - low_cyc - 1);
   endfunction : slot_rest

   wire                       cur_bit   = sh_r[0];
   wire [CNT_W-1:0]           wlow_len  = cur_bit ? CNT_W'(WR1_LOW_CYC) : CNT_W'(WR0_LOW_CYC);
   wire                       cnt_end   = (cnt_r == '0);
   wire                       take      = start && (st_r == M_IDLE);
   wire                       pres_end  = (st_r == M_PRES) && cnt_end;
   wire                       pres_seen = pres_r || !bus.line;
   wire                       wlow_end  = (cnt_r == CNT_W'(WR0_LOW_CYC) - wlow_len);
   wire                       wr_done   = (st_r == M_WREC) && cnt_end;
   wire                       rd_done   = (st_r == M_RWAIT) && cnt_end;
   wire                       rd_sample = (st_r == M_RWAIT) && (cnt_r == slot_rest(RD_SAMPLE_CYC));
   wire                       last_bit  = (bit_r == LAST_BIT_IN_BYTE);
   wire                       last_byte = (byte_r == LAST_BYTE);
   wire                       byte_done = rd_done && last_bit;
   wire                       code_done = byte_done && last_byte;
   wire [7:0]                 rx_nxt    = {bus.line, rx_r[7:1]};

   assign busy = (st_r != M_IDLE);
   // Line only pulled low, never driven high
   assign bus.m_oe = (st_r == M_RLOW) || (st_r == M_WLOW) || (st_r == M_RLOWR);

   genvar g;
   generate
      for (g = 0; g < CODE_BYTES; g++) begin : g_out
         assign serial_code_buffer[g*8 +: 8] = buf_r[CODE_BYTES-1-g];
      end
   endgenerate

   // Phase sequencing; counter runs down to zero and waits
   always_comb begin
      st_nxt  = st_r;
      cnt_nxt = cnt_end ? cnt_r : cnt_r - 1'b1;
      unique case (st_r)
         M_IDLE: begin
            if (start) begin
               st_nxt  = M_RLOW;
               cnt_nxt = span(RST_LOW_CYC);
            end
         end
         M_RLOW: begin
            if (cnt_end) begin
               st_nxt  = M_PRES;
               cnt_nxt = span(PRES_WIN_CYC);
            end
         end
         M_PRES: begin
            if (pres_end && pres_seen) begin
               st_nxt  = M_WLOW;
               cnt_nxt = span(WR0_LOW_CYC);
            end else if (pres_end) begin
               st_nxt  = M_IDLE;
            end
         end
         M_WLOW: begin
            // Write-one slots leave the low phase early
            if (wlow_end) begin
               st_nxt  = M_WREC;
               cnt_nxt = slot_rest(int'(wlow_len));
            end
         end
         M_WREC: begin
            if (wr_done && last_bit) begin
               st_nxt  = M_RLOWR;
               cnt_nxt = span(RD_LOW_CYC);
            end else if (wr_done) begin
               st_nxt  = M_WLOW;
               cnt_nxt = span(WR0_LOW_CYC);
            end
         end
         M_RLOWR: begin
            if (cnt_end) begin
               st_nxt  = M_RWAIT;
               cnt_nxt = slot_rest(RD_LOW_CYC);
            end
         end
         M_RWAIT: begin
            if (code_done) begin
               st_nxt  = M_IDLE;
            end else if (rd_done) begin
               st_nxt  = M_RLOWR;
               cnt_nxt = span(RD_LOW_CYC);
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_r  <= M_IDLE;
         cnt_r <= '0;
      end else if (clk_en) begin
         st_r  <= st_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Command bits leave from bit 0 of the shifter
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         sh_r  <= '0;
         bit_r <= '0;
      end else if (clk_en) begin
         if (pres_end) begin
            sh_r  <= CMD_READ_ID;
            bit_r <= '0;
         end else if (wr_done) begin
            sh_r  <= {1'b0, sh_r[7:1]};
            bit_r <= bit_r + 1'b1;
         end else if (rd_done) begin
            bit_r <= bit_r + 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         byte_r <= '0;
         pres_r <= 1'b0;
      end else if (clk_en) begin
         if (wr_done && last_bit) begin
            byte_r <= '0;
         end else if (byte_done) begin
            byte_r <= byte_r + 1'b1;
         end
         if (st_r == M_RLOW) begin
            pres_r <= 1'b0;
         end else if (st_r == M_PRES && !bus.line) begin
            pres_r <= 1'b1;
         end
      end
   end

   // Received bytes fill the buffer from the top
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rx_r <= '0;
         for (int i = 0; i < CODE_BYTES; i++) begin
            buf_r[i] <= '0;
         end
      end else if (clk_en) begin
         if (rd_sample) begin
            rx_r <= rx_nxt;
         end
         if (byte_done) begin
            buf_r[CODE_BYTES-1-int'(byte_r)] <= rx_r;
         end
      end
   end

   // Status flags stand until the next accepted start
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         done_r <= 1'b0;
         err_r  <= 1'b0;
      end else if (clk_en) begin
         if (take) begin
            done_r <= 1'b0;
            err_r  <= 1'b0;
         end else begin
            if (code_done) begin
               done_r <= 1'b1;
            end
            if (pres_end && !pres_seen) begin
               err_r <= 1'b1;
            end
         end
      end
   end
endmodule : swid_master

/* swid_slave.sv */
/*
 Serial-number slave end: answers reset with presence, takes an
 eight-bit command, returns its 64-bit code for the read command.
 Assumes the line input is synchronous to sys_clk.
*/
`timescale 1ns/1ps
module swid_slave
   import swid_pkg::*;
(
   input  wire logic                 sys_clk,
   input  wire logic                 srst,
   input  wire logic                 clk_en,
   swid_if.slave                     bus,
   input  wire logic [7:0]           family,
   input  wire logic [47:0]          serial,
   input  wire logic [7:0]           crc,
   output logic [7:0]                cmd_r,
   output logic                      search_r
);
   typedef enum logic [4:0] {
      S_IDLE = 5'h01,
      S_PW   = 5'h02,
      S_PRES = 5'h04,
      S_CMD  = 5'h08,
      S_TX   = 5'h10
   } swid_slv_t;

   swid_slv_t             st_r;
   logic [CNT_W-1:0]      low_r;
   logic [CNT_W-1:0]      t_r;
   logic                  line_d_r;
   logic                  drv_r;
   logic [BIT_W-1:0]      n_r;
   logic [7:0]            sh_r;

   wire [CODE_BITS-1:0]   code   = {crc, serial, family};
   wire                   fall   = line_d_r && !bus.line;
   wire                   is_rst = bus.line && !line_d_r && (low_r >= CNT_W'(S_RST_MIN_CYC));
   wire                   tx_bit = code[n_r[5:0]];
   wire                   tx_end = (n_r > LAST_CODE_BIT);

   assign bus.s_oe = drv_r;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_r     <= S_IDLE;
         low_r    <= '0;
         t_r      <= '0;
         line_d_r <= 1'b1;
         drv_r    <= 1'b0;
         n_r      <= '0;
         sh_r     <= '0;
         cmd_r    <= '0;
         search_r <= 1'b0;
      end else if (clk_en) begin
         line_d_r <= bus.line;
         low_r    <= bus.line ? '0 : low_r + 1'b1;
         if (t_r != '0) t_r <= t_r - 1'b1;
         if (is_rst) begin
            st_r  <= S_PW;
            t_r   <= CNT_W'(S_PRES_WAIT_CYC);
            drv_r <= 1'b0;
         end else begin
            unique case (st_r)
               S_IDLE: drv_r <= 1'b0;
               S_PW: if (t_r == '0) begin
                  st_r  <= S_PRES;
                  drv_r <= 1'b1;
                  t_r   <= CNT_W'(S_PRES_CYC);
               end
               S_PRES: if (t_r == '0) begin
                  st_r  <= S_CMD;
                  drv_r <= 1'b0;
                  n_r   <= '0;
               end
               S_CMD: begin
                  if (fall) t_r <= CNT_W'(S_SAMPLE_CYC);
                  else if (t_r == CNT_W'(1)) begin
                     sh_r <= {bus.line, sh_r[7:1]};
                     n_r  <= n_r + 1'b1;
                     if (n_r[2:0] == LAST_BIT_IN_BYTE) begin
                        cmd_r <= {bus.line, sh_r[7:1]};
                        n_r   <= '0;
                        if ({bus.line, sh_r[7:1]} == CMD_READ_ID) st_r <= S_TX;
                        else begin
                           st_r     <= S_IDLE;
                           search_r <= ({bus.line, sh_r[7:1]} == CMD_SEARCH);
                        end
                     end
                  end
               end
               S_TX: begin
                  // Last bit keeps its full drive time before idle
                  if (fall && !tx_end) begin
                     drv_r <= !tx_bit;
                     t_r   <= CNT_W'(S_DRIVE0_CYC);
                     n_r   <= n_r + 1'b1;
                  end else if (t_r == '0) begin
                     drv_r <= 1'b0;
                     if (tx_end) begin
                        st_r <= S_IDLE;
                     end
                  end
               end
            endcase
         end
      end
   end
endmodule : swid_slave

/* swid_link_props.sv */
/*
 Concurrent checks on the shared line and on the master status outputs.
 Assumes the master clk_en is tied high and one slave sits on the line.
*/
`timescale 1ns/1ps
module swid_link_props
   import swid_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic srst,
   input  wire logic m_oe,
   input  wire logic s_oe,
   input  wire logic line,
   input  wire logic start,
   input  wire logic busy,
   input  wire logic done_r,
   input  wire logic err_r
);
   logic [15:0] low_cnt_r;
   logic [15:0] high_cnt_r;
   logic [7:0]  pulse_cnt_r;
   logic        saw_pres_r;
   wire         take = start & ~busy;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   always_ff @(posedge sys_clk) begin
      if (srst | ~m_oe) begin
         low_cnt_r <= 16'h0000;
      end else begin
         low_cnt_r <= low_cnt_r + 16'h0001;
      end
   end
   // Released time since last pull, saturating
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         high_cnt_r <= 16'hFFFF;
      end else if (m_oe) begin
         high_cnt_r <= 16'h0000;
      end else if (high_cnt_r != 16'hFFFF) begin
         high_cnt_r <= high_cnt_r + 16'h0001;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (srst | take) begin
         pulse_cnt_r <= 8'h00;
         saw_pres_r  <= 1'b0;
      end else begin
         if (m_oe && low_cnt_r == 16'h0000) begin
            pulse_cnt_r <= pulse_cnt_r + 8'h01;
         end
         if (busy & ~m_oe & ~line) begin
            saw_pres_r <= 1'b1;
         end
      end
   end
   property p_start_reset; take |=> m_oe; endproperty
   a_start_reset: assert property (p_start_reset) else $error("start did not pull line");
   property p_low_width;
      $fell(m_oe) |-> low_cnt_r inside {RST_LOW_CYC, WR1_LOW_CYC, WR0_LOW_CYC, RD_LOW_CYC};
   endproperty
   a_low_width: assert property (p_low_width) else $error("bad low pulse width");
   property p_recovery; $rose(m_oe) |-> high_cnt_r >= REC_CYC; endproperty
   a_recovery: assert property (p_recovery) else $error("recovery too short");
   property p_after_err; err_r && !start |=> !m_oe; endproperty
   a_after_err: assert property (p_after_err) else $error("line pulled after error");
   property p_after_done; done_r && !start |=> !m_oe && !busy; endproperty
   a_after_done: assert property (p_after_done) else $error("activity after done");
   property p_idle_release; !busy |-> !m_oe; endproperty
   a_idle_release: assert property (p_idle_release) else $error("idle master pulls");
   property p_slave_idle; !busy |-> !s_oe; endproperty
   a_slave_idle: assert property (p_slave_idle) else $error("slave pulls while idle");
   property p_err_cause; $rose(err_r) |-> !saw_pres_r; endproperty
   a_err_cause: assert property (p_err_cause) else $error("error despite presence");
   property p_done_cause; $rose(done_r) |-> saw_pres_r && pulse_cnt_r == 8'h49; endproperty
   a_done_cause: assert property (p_done_cause) else $error("done with wrong slots");
endmodule : swid_link_props

/* single_wire_serial_id_read_tb.sv */
/*
 Testbench joining master and slave: a run with no presence, then an
 identity read checked on the wire and in the buffer.
 Assumes the package timing counts at 50 MHz.
*/
`timescale 1ns/1ps
`define CHK(a, e, m) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; $display("BAD %0t %s", $time, m); end end
module single_wire_serial_id_read_tb;
   import swid_pkg::*;
   logic        sys_clk = 1'b0;
   logic        srst    = 1'b1;
   logic        start   = 1'b0;
   logic        s_en    = 1'b0;
   logic        busy, done_r, err_r, search_r;
   logic [63:0] serial_code_buffer;
   logic [7:0]  cmd_r;
   logic [7:0]  family  = 8'h2D;
   logic [47:0] serial  = 48'hC3A1_5E0F_7B96;
   logic [7:0]  crc     = 8'h4E;
   int          n_mismatch = 0;
   int          checks_done = 0;
   int          lo = 0;
   int          n_pulse = 0;
   int          wid [0:79];
   swid_if bus ();
   swid_master u_swid_master (.sys_clk(sys_clk), .srst(srst), .clk_en(1'b1), .bus(bus.master), .start(start),
      .busy(busy), .done_r(done_r), .err_r(err_r), .serial_code_buffer(serial_code_buffer));
   swid_slave u_swid_slave (.sys_clk(sys_clk), .srst(srst), .clk_en(s_en), .bus(bus.slave), .family(family),
      .serial(serial), .crc(crc), .cmd_r(cmd_r), .search_r(search_r));
   swid_link_props u_swid_link_props (.sys_clk(sys_clk), .srst(srst), .m_oe(bus.m_oe), .s_oe(bus.s_oe),
      .line(bus.line), .start(start), .busy(busy), .done_r(done_r), .err_r(err_r));
   always #10 sys_clk = ~sys_clk;
   // Low pulse widths of the master, in order
   always @(posedge sys_clk) begin
      if (bus.m_oe) begin
         lo <= lo + 1;
      end else if (lo != 0) begin
         if (n_pulse < 80) wid[n_pulse] <= lo;
         n_pulse <= n_pulse + 1;
         lo <= 0;
      end
   end
   task automatic finish_test();
      if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : finish_test
   task automatic run(input logic exp_err);
      int t;
      @(posedge sys_clk);
      n_pulse <= 0;
      start <= 1'b1;
      @(posedge sys_clk);
      start <= 1'b0;
      @(posedge sys_clk);
      t = 0;
      // Extra start mid-transaction must be ignored
      while (!(done_r === 1'b1 || err_r === 1'b1) && t < 300000) begin
         start <= (t == 1000);
         @(posedge sys_clk);
         t++;
      end
      start <= 1'b0;
      @(posedge sys_clk);
      `CHK(err_r, exp_err, "error flag")
      `CHK(done_r, ~exp_err, "done flag")
      `CHK(busy, 1'b0, "busy after end")
      `CHK(wid[0], RST_LOW_CYC, "reset pulse width")
      `CHK(n_pulse, exp_err ? 1 : 73, "pulse count")
      if (!exp_err) begin
         for (int i = 0; i < 8; i++)
            `CHK(wid[1+i], CMD_READ_ID[i] ? WR1_LOW_CYC : WR0_LOW_CYC, "write slot")
         for (int i = 9; i < 73; i++)
            `CHK(wid[i], RD_LOW_CYC, "read slot")
      end
   endtask : run
   initial begin
      repeat (12) @(posedge sys_clk);
      srst <= 1'b0;
      repeat (100) @(posedge sys_clk);
      `CHK(bus.line, 1'b1, "line not idle high")
      run(1'b1);
      s_en <= 1'b1;
      run(1'b0);
      `CHK(serial_code_buffer, {crc, serial, family}, "code buffer")
      `CHK(cmd_r, CMD_READ_ID, "slave command")
      `CHK(search_r, 1'b0, "search flag")
      finish_test();
   end
   initial begin
      repeat (400000) @(posedge sys_clk);
      n_mismatch++;
      finish_test();
   end
endmodule : single_wire_serial_id_read_tb
